// ==== hdl/hurp_pkg.sv ====
// shared constants and types of the host register port
package hurp_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [2:0] HURP_OFF_DATA  = 3'h0;
  localparam logic [2:0] HURP_OFF_IEN   = 3'h1;
  localparam logic [2:0] HURP_OFF_IID   = 3'h2;
  localparam logic [2:0] HURP_OFF_LFMT  = 3'h3;
  localparam logic [2:0] HURP_OFF_MCTL  = 3'h4;
  localparam logic [2:0] HURP_OFF_LSTAT = 3'h5;
  localparam logic [2:0] HURP_OFF_MSTAT = 3'h6;
  localparam logic [2:0] HURP_OFF_SPARE = 3'h7;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int HURP_FC_EN      = 0;
  localparam int HURP_FC_RXCLR   = 1;
  localparam int HURP_FC_TXCLR   = 2;
  localparam int HURP_FC_DMA     = 3;
  localparam int HURP_FC_TRIG_LO = 6;
  localparam int HURP_LF_DIVSEL  = 7;
  localparam int HURP_IE_RXD     = 0;
  localparam int HURP_IE_THE     = 1;
  localparam int HURP_IE_LST     = 2;
  localparam int HURP_IE_MST     = 3;
  // ------------------------------------------------------------
  // reset values, trigger levels, identity codes
  // ------------------------------------------------------------
  localparam logic [7:0] HURP_RST_BYTE = 8'h00;
  localparam logic [4:0] HURP_TRIG_0   = 5'h01;
  localparam logic [4:0] HURP_TRIG_1   = 5'h04;
  localparam logic [4:0] HURP_TRIG_2   = 5'h08;
  localparam logic [4:0] HURP_TRIG_3   = 5'h0e;
  localparam logic [2:0] HURP_ID_LST   = 3'h3;
  localparam logic [2:0] HURP_ID_RXD   = 3'h2;
  localparam logic [2:0] HURP_ID_THE   = 3'h1;
  localparam logic [2:0] HURP_ID_MST   = 3'h0;
  localparam int         HURP_DEPTH    = 16;
  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic       brk;
    logic       frame;
    logic       parity;
    logic [7:0] data;
  } hurp_rx_entry_type;
endpackage

// ==== hdl/hurp_port.sv ====
// host register port with its receive and transmit fifos
`timescale 1ns/1ps
`default_nettype none
module hurp_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     flush,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [W-1:0]             in_data,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [W-1:0]                  out_data,
  output logic [$clog2(D+1)-1:0]        count
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic          push;
  logic          pop;
  assign in_ready  = (count != D[$clog2(D+1)-1:0]);
  assign out_valid = (count != '0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wp_q  <= '0;
      rp_q  <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
      end
      count <= count + {{($clog2(D+1)-1){1'b0}}, push} - {{($clog2(D+1)-1){1'b0}}, pop};
    end
  end
endmodule // hurp_fifo

module hurp_port
  import hurp_pkg::*;
#(
  parameter int DEPTH = HURP_DEPTH
) (
  // clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       SYS_RST,
  // host pins
  input  wire logic       HOST_CS_N,
  input  wire logic       HOST_READ_STROBE_N,
  input  wire logic       HOST_WRITE_STROBE_N,
  input  wire logic [2:0] HOST_ADDR,
  input  wire logic [7:0] HOST_DATA_IN,
  output logic      [7:0] HOST_DATA_OUT,
  output logic            HOST_DATA_OE,
  // modem receive stream
  input  wire logic       MDM_RX_VALID,
  output logic            MDM_RX_READY,
  input  wire hurp_rx_entry_type MDM_RX_ENTRY,
  // modem transmit stream
  output logic            MDM_TX_VALID,
  input  wire logic       MDM_TX_READY,
  output logic      [7:0] MDM_TX_DATA,
  input  wire logic       MDM_TX_IDLE,
  // modem side status and settings
  input  wire logic [7:0] MDM_STATUS,
  output logic      [7:0] LINE_FORMAT,
  output logic      [7:0] MODEM_CONTROL,
  output logic     [15:0] DIVISOR,
  output logic            DMA_RX_READY,
  output logic            DMA_TX_READY
);
  localparam int CW = $clog2(DEPTH+1);
  // ------------------------------------------------------------
  // pin synchronisers and strobe edges
  // ------------------------------------------------------------
  logic [13:0] s1_q, s2_q;
  logic        rd_n_q3, wr_n_q3;
  logic        cs_s, rd_s, wr_s;
  logic [2:0]  a_s;
  logic [7:0]  d_s;
  logic        rd_ev, wr_ev;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      s1_q <= 14'h3fff;
      s2_q <= 14'h3fff;
    end else begin
      s1_q <= {HOST_CS_N, HOST_READ_STROBE_N, HOST_WRITE_STROBE_N, HOST_ADDR, HOST_DATA_IN};
      s2_q <= s1_q;
    end
  end
  assign {cs_s, rd_s, wr_s, a_s, d_s} = s2_q;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      rd_n_q3 <= 1'b1;
      wr_n_q3 <= 1'b1;
    end else begin
      rd_n_q3 <= rd_s;
      wr_n_q3 <= wr_s;
    end
  end
  assign rd_ev = rd_n_q3 && !rd_s && !cs_s;
  assign wr_ev = !wr_n_q3 && wr_s && !cs_s;
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0]  ien_q, lfmt_q, mctl_q, spare_q;
  logic [15:0] div_q;
  logic        fen_q, dma_q;
  logic [1:0]  trig_q;
  logic        divsel, wr_fc;
  assign divsel = lfmt_q[HURP_LF_DIVSEL];
  assign wr_fc  = wr_ev && a_s == HURP_OFF_IID;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ien_q   <= HURP_RST_BYTE;
      lfmt_q  <= HURP_RST_BYTE;
      mctl_q  <= HURP_RST_BYTE;
      spare_q <= HURP_RST_BYTE;
      div_q   <= {HURP_RST_BYTE, HURP_RST_BYTE};
    end else if (wr_ev) begin
      case (a_s)
        HURP_OFF_DATA:  if (divsel) div_q[7:0] <= d_s;
        HURP_OFF_IEN:   if (divsel) div_q[15:8] <= d_s; else ien_q <= d_s & 8'h0f;
        HURP_OFF_LFMT:  lfmt_q <= d_s;
        HURP_OFF_MCTL:  mctl_q <= d_s & 8'h1f;
        HURP_OFF_SPARE: spare_q <= d_s;
        default: ;
      endcase
    end
  end
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      fen_q  <= 1'b0;
      dma_q  <= 1'b0;
      trig_q <= 2'h0;
    end else if (wr_fc) begin
      fen_q <= d_s[HURP_FC_EN];
      if (d_s[HURP_FC_EN]) begin
        dma_q  <= d_s[HURP_FC_DMA];
        trig_q <= d_s[HURP_FC_TRIG_LO +: 2];
      end else begin
        dma_q <= 1'b0;
      end
    end
  end
  // ------------------------------------------------------------
  // fifos
  // ------------------------------------------------------------
  hurp_rx_entry_type rx_head;
  logic [CW-1:0] rx_cnt, tx_cnt;
  logic          rx_in_rdy, rx_nonempty, tx_in_rdy;
  logic          rx_pop, tx_push;
  logic          rx_flush, tx_flush, fc_clear;
  logic          rx_room, tx_room;
  assign fc_clear = wr_fc && (!d_s[HURP_FC_EN] || !fen_q);
  assign rx_flush = fc_clear || (wr_fc && d_s[HURP_FC_EN] && d_s[HURP_FC_RXCLR]);
  assign tx_flush = fc_clear || (wr_fc && d_s[HURP_FC_EN] && d_s[HURP_FC_TXCLR]);
  assign rx_room  = rx_in_rdy && (fen_q || rx_cnt == '0);
  assign tx_room  = tx_in_rdy && (fen_q || tx_cnt == '0);
  assign rx_pop   = rd_ev && a_s == HURP_OFF_DATA && !divsel;
  assign tx_push  = wr_ev && a_s == HURP_OFF_DATA && !divsel && tx_room;
  assign MDM_RX_READY = rx_room;
  hurp_fifo #(.W($bits(hurp_rx_entry_type)), .D(DEPTH)) u_rx (
    .clk(CORE_CLK), .rst(SYS_RST), .flush(rx_flush),
    .in_valid(MDM_RX_VALID && rx_room), .in_ready(rx_in_rdy), .in_data(MDM_RX_ENTRY),
    .out_valid(rx_nonempty), .out_ready(rx_pop), .out_data(rx_head), .count(rx_cnt)
  );
  hurp_fifo #(.W(8), .D(DEPTH)) u_tx (
    .clk(CORE_CLK), .rst(SYS_RST), .flush(tx_flush),
    .in_valid(tx_push), .in_ready(tx_in_rdy), .in_data(d_s),
    .out_valid(MDM_TX_VALID), .out_ready(MDM_TX_READY), .out_data(MDM_TX_DATA),
    .count(tx_cnt)
  );
  // ------------------------------------------------------------
  // line status and interrupt identity
  // ------------------------------------------------------------
  function automatic logic [CW-1:0] trig_level(input logic [1:0] code);
    case (code)
      2'h0:    trig_level = CW'(HURP_TRIG_0);
      2'h1:    trig_level = CW'(HURP_TRIG_1);
      2'h2:    trig_level = CW'(HURP_TRIG_2);
      default: trig_level = CW'(HURP_TRIG_3);
    endcase
  endfunction
  logic [3:0] err_q;
  logic       fifo_err_q;
  logic [7:0] mstat_q;
  logic [7:0] lstat;
  logic [7:0] iid;
  logic       rx_hit;
  logic       rd_lstat;
  logic [2:0] head_err;
  assign rd_lstat = rd_ev && a_s == HURP_OFF_LSTAT;
  assign head_err = rx_nonempty ? {rx_head.brk, rx_head.frame, rx_head.parity} : 3'h0;
  assign rx_hit   = fen_q ? (rx_cnt >= trig_level(trig_q)) : rx_nonempty;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      err_q      <= 4'h0;
      fifo_err_q <= 1'b0;
      mstat_q    <= HURP_RST_BYTE;
    end else begin
      mstat_q    <= MDM_STATUS;
      err_q      <= (rd_lstat ? 4'h0 : err_q)
                  | {head_err, MDM_RX_VALID && !rx_room};
      fifo_err_q <= (rd_lstat ? 1'b0 : fifo_err_q) | (fen_q && |head_err);
    end
  end
  assign lstat = {fifo_err_q, !MDM_TX_VALID && MDM_TX_IDLE, !MDM_TX_VALID,
                  err_q, rx_nonempty};
  always_comb begin
    iid = {fen_q, fen_q, 6'h01};
    if (ien_q[HURP_IE_LST] && |err_q) begin
      iid[3:0] = {HURP_ID_LST, 1'b0};
    end else if (ien_q[HURP_IE_RXD] && rx_hit) begin
      iid[3:0] = {HURP_ID_RXD, 1'b0};
    end else if (ien_q[HURP_IE_THE] && !MDM_TX_VALID) begin
      iid[3:0] = {HURP_ID_THE, 1'b0};
    end else if (ien_q[HURP_IE_MST] && |mstat_q[3:0]) begin
      iid[3:0] = {HURP_ID_MST, 1'b0};
    end
  end
  // ------------------------------------------------------------
  // read data and outputs
  // ------------------------------------------------------------
  logic [7:0] rdata_q;
  logic       rxrdy_q;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      rdata_q <= HURP_RST_BYTE;
    end else if (rd_ev) begin
      case (a_s)
        HURP_OFF_DATA:  rdata_q <= divsel ? div_q[7:0] : rx_head.data;
        HURP_OFF_IEN:   rdata_q <= divsel ? div_q[15:8] : ien_q;
        HURP_OFF_IID:   rdata_q <= iid;
        HURP_OFF_LFMT:  rdata_q <= lfmt_q;
        HURP_OFF_MCTL:  rdata_q <= mctl_q;
        HURP_OFF_LSTAT: rdata_q <= lstat;
        HURP_OFF_MSTAT: rdata_q <= mstat_q;
        default:        rdata_q <= spare_q;
      endcase
    end
  end
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || !rx_nonempty) begin
      rxrdy_q <= 1'b0;
    end else if (rx_hit) begin
      rxrdy_q <= 1'b1;
    end
  end
  assign HOST_DATA_OUT = rdata_q;
  assign HOST_DATA_OE  = !cs_s && !rd_s && rd_n_q3 == 1'b0;
  assign LINE_FORMAT   = lfmt_q;
  assign MODEM_CONTROL = mctl_q;
  assign DIVISOR       = div_q;
  assign DMA_RX_READY  = (fen_q && dma_q) ? rxrdy_q : rx_nonempty;
  assign DMA_TX_READY  = (fen_q && dma_q) ? tx_in_rdy : !MDM_TX_VALID;
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_fc_off;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    wr_fc && !d_s[HURP_FC_EN] |=> !fen_q && !dma_q && rx_cnt == '0 && tx_cnt == '0;
  endproperty
  a_fc_off: assert property (p_fc_off) else $error("fifo disable failed");
  property p_fc_on;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    wr_fc && d_s[HURP_FC_EN] |=> fen_q && dma_q == $past(d_s[HURP_FC_DMA]);
  endproperty
  a_fc_on: assert property (p_fc_on) else $error("fifo enable failed");
  property p_legacy;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    !fen_q |-> tx_cnt <= CW'(1) && rx_cnt <= CW'(1);
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy depth exceeded");
  property p_depth;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    rx_cnt <= CW'(DEPTH) && tx_cnt <= CW'(DEPTH);
  endproperty
  a_depth: assert property (p_depth) else $error("fifo overfilled");
  property p_rxread;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    rx_pop && rx_nonempty |=> rdata_q == $past(rx_head.data);
  endproperty
  a_rxread: assert property (p_rxread) else $error("receive byte wrong");
  property p_divlo;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    wr_ev && divsel && a_s == HURP_OFF_DATA
      |=> div_q[7:0] == $past(d_s) && tx_cnt <= $past(tx_cnt);
  endproperty
  a_divlo: assert property (p_divlo) else $error("divisor low not loaded");
  property p_iid;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    rd_ev && a_s == HURP_OFF_IID |=> rdata_q[5:4] == 2'h0 && rdata_q[7:6] == {2{$past(fen_q)}};
  endproperty
  a_iid: assert property (p_iid) else $error("identity byte wrong");
  property p_lstat;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    rd_lstat |=> rdata_q[0] == $past(rx_nonempty) && rdata_q[5] == $past(!MDM_TX_VALID);
  endproperty
  a_lstat: assert property (p_lstat) else $error("line status wrong");
  property p_lfmt;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    wr_ev && a_s == HURP_OFF_LFMT |=> LINE_FORMAT == $past(d_s);
  endproperty
  a_lfmt: assert property (p_lfmt) else $error("format not stored");
endmodule // hurp_port
`default_nettype wire

// ==== verif/hurp_modem_model.sv ====
// modem side stand-in: feeds receive entries and takes transmit bytes
`timescale 1ns/1ps
`default_nettype none
module hurp_modem_model
  import hurp_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // receive stream toward the port
  output logic              rx_valid,
  input  wire logic         rx_ready,
  output hurp_rx_entry_type rx_entry,
  // transmit stream from the port
  input  wire logic         tx_valid,
  output logic              tx_ready,
  input  wire logic [7:0]   tx_data,
  output logic              tx_idle,
  // bench control
  input  wire logic         stall
);
  hurp_rx_entry_type rx_q[$];
  logic [7:0]        tx_seen[$];
  logic              slow;
  // ------------------------------------------------------------
  // queue a received byte
  // ------------------------------------------------------------
  task automatic push(input logic [7:0] b);
    rx_q.push_back({3'h0, b});
  endtask
  task automatic push_entry(input hurp_rx_entry_type e);
    rx_q.push_back(e);
  endtask
  initial begin
    rx_valid = 1'b0;
    rx_entry = '0;
    tx_ready = 1'b0;
    tx_idle  = 1'b1;
    slow     = 1'b0;
  end
  // handshakes complete on the rising edge
  always @(posedge clk) begin
    if (!rst && rx_valid && rx_ready)
      void'(rx_q.pop_front());
    if (!rst && tx_valid && tx_ready)
      tx_seen.push_back(tx_data);
  end
  // offer held until taken; idle entry shows inverted junk
  always @(negedge clk) begin
    slow     <= ~slow;
    tx_ready <= !stall && slow;
    tx_idle  <= !stall;
    rx_valid <= (rx_q.size() > 0);
    rx_entry <= (rx_q.size() > 0) ? rx_q[0] : ~rx_entry;
  end
endmodule // hurp_modem_model
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench of the host register port
`timescale 1ns/1ps
`default_nettype none
module tb
  import hurp_pkg::*;
;
  logic              clk, rst, cs_n, rd_n, wr_n, stall, oe, rxv, rxr, txv, txr, txi, dmar, dmat;
  logic [2:0]        addr;
  logic [7:0]        din, dout, status, lfmt, mctl, txd, v;
  logic [15:0]       div;
  hurp_rx_entry_type rxe;
  int                mismatches, check_count, seed, i, c, n;
  logic [7:0]        exp_q[$];

  hurp_port dut_u (.CORE_CLK(clk), .SYS_RST(rst), .HOST_CS_N(cs_n), .HOST_READ_STROBE_N(rd_n),
    .HOST_WRITE_STROBE_N(wr_n), .HOST_ADDR(addr), .HOST_DATA_IN(din), .HOST_DATA_OUT(dout),
    .HOST_DATA_OE(oe), .MDM_RX_VALID(rxv), .MDM_RX_READY(rxr), .MDM_RX_ENTRY(rxe),
    .MDM_TX_VALID(txv), .MDM_TX_READY(txr), .MDM_TX_DATA(txd), .MDM_TX_IDLE(txi),
    .MDM_STATUS(status), .LINE_FORMAT(lfmt), .MODEM_CONTROL(mctl), .DIVISOR(div),
    .DMA_RX_READY(dmar), .DMA_TX_READY(dmat));
  hurp_modem_model modem_u (.clk(clk), .rst(rst), .rx_valid(rxv), .rx_ready(rxr),
    .rx_entry(rxe), .tx_valid(txv), .tx_ready(txr), .tx_data(txd), .tx_idle(txi),
    .stall(stall));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic hw(input logic [2:0] a, input logic [7:0] d);
    cs_n = 1'b0; addr = a; din = d; wr_n = 1'b0; cyc(5);
    wr_n = 1'b1; cyc(5);
    cs_n = 1'b1; din = ~d; cyc(1);
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] exp);
    cs_n = 1'b0; addr = a; rd_n = 1'b0; cyc(6);
    chk({7'h00, oe, dout}, {8'h01, exp});
    rd_n = 1'b1; cyc(5);
    chk({7'h00, oe, dout}, {8'h00, exp});
    cs_n = 1'b1; cyc(1);
  endtask
  task automatic settle;
    for (int k = 0; k < 300 && modem_u.rx_q.size() > 0; k++) cyc(1);
    cyc(4);
  endtask
  task automatic feed(input logic [7:0] b);
    modem_u.push(b);
    exp_q.push_back(b);
  endtask
  function automatic int trig(input int code);
    case (code)
      0: return 1;
      1: return 4;
      2: return 8;
      default: return 14;
    endcase
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  initial begin
    #400000;
    mismatches++;
    tally_and_finish();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1; cs_n = 1'b1; rd_n = 1'b1; wr_n = 1'b1; addr = 3'h0; din = 8'h00;
    stall = 1'b0; status = 8'h00; seed = 65; mismatches = 0; check_count = 0;
    cyc(10);
    rst = 1'b0;
    cyc(3);
    for (i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      hw(HURP_OFF_SPARE, v);
      rc(HURP_OFF_SPARE, v);
    end
    v = 8'($random(seed));
    hw(HURP_OFF_LFMT, {1'b0, v[6:0]});
    chk(lfmt, {1'b0, v[6:0]});
    rc(HURP_OFF_LFMT, {1'b0, v[6:0]});
    hw(HURP_OFF_MCTL, 8'hff);
    chk(mctl, 8'h1f);
    rc(HURP_OFF_MCTL, 8'h1f);
    hw(HURP_OFF_IEN, 8'hff);
    rc(HURP_OFF_IEN, 8'h0f);
    status = 8'($random(seed));
    cyc(3);
    rc(HURP_OFF_MSTAT, status);
    $display("test registers done");
    hw(HURP_OFF_LFMT, 8'h80);
    hw(HURP_OFF_DATA, 8'h34);
    hw(HURP_OFF_IEN, 8'h12);
    chk(div, 16'h1234);
    rc(HURP_OFF_DATA, 8'h34);
    rc(HURP_OFF_IEN, 8'h12);
    hw(HURP_OFF_LFMT, 8'h00);
    chk(16'(modem_u.tx_seen.size()), 16'h0);
    rc(HURP_OFF_IEN, 8'h0f);
    hw(HURP_OFF_IEN, 8'h00);
    rc(HURP_OFF_IID, 8'h01);
    rc(HURP_OFF_LSTAT, 8'h60);
    $display("test divisor done");
    v = 8'($random(seed));
    feed(v);
    settle();
    rc(HURP_OFF_LSTAT, 8'h61);
    rc(HURP_OFF_DATA, exp_q.pop_front());
    rc(HURP_OFF_LSTAT, 8'h60);
    stall = 1'b1;
    cyc(2);
    rc(HURP_OFF_LSTAT, 8'h20);
    hw(HURP_OFF_DATA, 8'h5a);
    hw(HURP_OFF_DATA, 8'ha5);
    rc(HURP_OFF_LSTAT, 8'h00);
    stall = 1'b0;
    cyc(20);
    chk(16'(modem_u.tx_seen.size()), 16'h1);
    chk(modem_u.tx_seen.pop_front(), 8'h5a);
    $display("test legacy done");
    hw(HURP_OFF_IID, 8'h01);
    rc(HURP_OFF_IID, 8'hc1);
    for (i = 0; i < 16; i++) feed(8'($random(seed)));
    settle();
    chk(rxr, 1'b0);
    for (i = 0; i < 16; i++) rc(HURP_OFF_DATA, exp_q.pop_front());
    rc(HURP_OFF_LSTAT, 8'h60);
    stall = 1'b1;
    for (i = 0; i < 17; i++) begin
      v = 8'($random(seed));
      hw(HURP_OFF_DATA, v);
      if (i < 16) exp_q.push_back(v);
    end
    chk(dmat, 1'b0);
    stall = 1'b0;
    for (i = 0; i < 300 && txv === 1'b1; i++) cyc(1);
    cyc(4);
    chk(16'(modem_u.tx_seen.size()), 16'h10);
    while (modem_u.tx_seen.size() > 0)
      chk(modem_u.tx_seen.pop_front(), exp_q.pop_front());
    hw(HURP_OFF_IEN, 8'h05);
    modem_u.push_entry({3'b010, 8'h3c});
    settle();
    rc(HURP_OFF_IID, 8'hc6);
    rc(HURP_OFF_LSTAT, 8'he9);
    rc(HURP_OFF_DATA, 8'h3c);
    rc(HURP_OFF_LSTAT, 8'he8);
    rc(HURP_OFF_LSTAT, 8'h60);
    feed(8'($random(seed)));
    settle();
    rc(HURP_OFF_IID, 8'hc4);
    rc(HURP_OFF_DATA, exp_q.pop_front());
    hw(HURP_OFF_IEN, 8'h07);
    rc(HURP_OFF_IID, 8'hc2);
    hw(HURP_OFF_IEN, 8'h00);
    $display("test fifo done");
    for (c = 0; c < 4; c++) begin
      n = trig(c);
      hw(HURP_OFF_IID, {c[1:0], 6'h0b});
      for (i = 0; i < n - 1; i++) modem_u.push(8'($random(seed)));
      settle();
      chk(dmar, 1'b0);
      modem_u.push(8'($random(seed)));
      settle();
      chk(dmar, 1'b1);
    end
    hw(HURP_OFF_IID, 8'hce);
    rc(HURP_OFF_IID, 8'h01);
    modem_u.push(8'h77);
    settle();
    chk(dmar, 1'b1);
    rc(HURP_OFF_DATA, 8'h77);
    $display("test trigger done");
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
